// file: hw/swb_pkg.sv
package swb_pkg;

   // register offsets
   localparam logic [7:0] REG_MODE      = 8'h00;
   localparam logic [7:0] REG_LAT       = 8'h04;
   localparam logic [7:0] REG_STATUS    = 8'h08;
   localparam logic [7:0] REG_ERR       = 8'h0C;
   localparam logic [7:0] REG_PEEK_ADDR = 8'h10;
   localparam logic [7:0] REG_PEEK_DATA = 8'h14;

   // field positions
   localparam int MODE_BL_LSB   = 0;
   localparam int MODE_MASK_BIT = 2;
   localparam int MODE_INV_BIT  = 3;
   localparam int MODE_CRC_BIT  = 4;
   localparam int MODE_PRE2_BIT = 5;
   localparam int LAT_AL_LSB    = 0;
   localparam int LAT_CWL_LSB   = 8;
   localparam int STAT_BANK_LSB = 0;
   localparam int STAT_CRC_BIT  = 4;
   localparam int STAT_BUSY_BIT = 5;
   localparam int STAT_CONF_BIT = 6;
   localparam int ERR_CWL_BIT   = 0;
   localparam int ERR_SPC_BIT   = 1;

   // widths
   localparam int MODE_W   = 6;
   localparam int AL_W     = 5;
   localparam int CWL_W    = 5;
   localparam int BANK_W   = 2;
   localparam int COLHI_W  = 2;
   localparam int MEM_AW   = BANK_W + COLHI_W + 3;
   localparam int BANKS    = 1 << BANK_W;

   // reset values
   localparam logic [MODE_W-1:0] MODE_RST = 6'h00;
   localparam logic [AL_W-1:0]   AL_RST   = 5'h00;
   localparam logic [CWL_W-1:0]  CWL_RST  = 5'h09;

   // burst-length codes
   localparam logic [1:0] BL_EIGHT  = 2'h0;
   localparam logic [1:0] BL_SELECT = 2'h1;
   localparam logic [1:0] BL_CHOP   = 2'h2;

   // timing counts, link clocks
   localparam logic [CWL_W-1:0] CWL_LOWEST     = 5'h09;
   localparam logic [2:0]       SPACING_BANNED = 3'h5;
   localparam logic [1:0]       FULL_LAST_CLK  = 2'h3;
   localparam logic [1:0]       CHOP_LAST_CLK  = 2'h1;
   localparam logic [1:0]       CHOP_KEEP_CLKS = 2'h2;

   typedef struct packed {
      logic [1:0]       burstLen;
      logic             maskEn;
      logic             invEn;
      logic             crcEn;
      logic             pre2;
      logic [AL_W-1:0]  al;
      logic [CWL_W-1:0] column_write_latency;
   } swb_cfg_t;

   typedef struct packed {
      logic [BANK_W-1:0]  bank;
      logic [COLHI_W-1:0] colHi;
      logic               chop;
      logic               fixedChop;
      logic               autoClose;
   } swb_cmd_t;

   typedef enum logic [1:0] {
      BST_IDLE = 2'b01,
      BST_RUN  = 2'b10
   } swb_burst_t;

endpackage

// file: hw/swb_write_burst.sv
`timescale 1ns/1ps
`default_nettype none
module swb_write_burst #(
   parameter int LANES      = 2,
   parameter int PEND_DEPTH = 16
) (
   // system
   input  wire logic                        mclk,
   input  wire logic                        rst_n,
   // register port
   input  wire logic [7:0]                  regAddr,
   input  wire logic [31:0]                 regWdata,
   input  wire logic                        regWr,
   input  wire logic                        regRd,
   output logic      [31:0]                 regRdata,
   // link commands
   input  wire logic                        lclk,
   input  wire logic                        actCmd,
   input  wire logic                        wrCmd,
   input  wire logic [swb_pkg::BANK_W-1:0]  cmdBank,
   input  wire logic [swb_pkg::COLHI_W-1:0] cmdColHi,
   input  wire logic                        addrBitTen,
   input  wire logic                        addrBitTwelve,
   // link data, rising beat low half
   input  wire logic [2*LANES*8-1:0]        dq,
   input  wire logic [2*LANES-1:0]          byteLaneMaskN,
   // link status
   output logic                             dataEnd,
   output logic                             autoCloseEvt,
   output logic      [swb_pkg::BANKS-1:0]   bankOpen
);

   localparam int PW    = $clog2(PEND_DEPTH);
   localparam int SLOTS = 2 * LANES;

   function automatic logic laneKeep(input logic maskEn, input logic invEn, input logic pinN);
      // pin acts as inversion flag when inversion is on, never as mask
      laneKeep = invEn ? 1'b1 : (maskEn ? pinN : 1'b1);
   endfunction

   function automatic logic [7:0] laneVal(input logic invEn, input logic pinN,
                                          input logic [7:0] d);
      laneVal = (invEn && !pinN) ? ~d : d;
   endfunction

   // register file, mclk
   logic [swb_pkg::MODE_W-1:0] modeReg_ff;
   logic [swb_pkg::AL_W-1:0]   alReg_ff;
   logic [swb_pkg::CWL_W-1:0]  cwlReg_ff;
   logic [swb_pkg::MEM_AW-1:0] peekAddr_ff;
   logic [1:0]                 err_ff;
   logic [31:0]                rdata_ff;
   swb_pkg::swb_cfg_t          curCfg;
   swb_pkg::swb_cfg_t          cfgHold_ff;
   logic                       reqTgl_ff;
   logic                       ackMeta_ff;
   logic                       ackSync_ff;
   logic [swb_pkg::BANKS-1:0]  bankMeta_ff;
   logic [swb_pkg::BANKS-1:0]  bankSync_ff;
   logic                       spMeta_ff;
   logic                       spSync_ff;
   logic                       spSeen_ff;
   logic                       cwlLow;
   logic                       spEvt;
   logic [1:0]                 errSet;

   // link domain
   logic                       lrstMeta_ff;
   logic                       lrst_n;
   logic                       reqMeta_ff;
   logic                       reqSync_ff;
   logic                       reqSeen_ff;
   swb_pkg::swb_cfg_t          lcfg_ff;
   logic [6:0]                 timer_ff;
   logic [6:0]                 sinceCmd_ff;
   logic [2:0]                 age_ff;
   logic                       spTgl_ff;
   swb_pkg::swb_cmd_t          pendInfo [0:PEND_DEPTH-1];
   logic [6:0]                 pendDue  [0:PEND_DEPTH-1];
   logic [PW-1:0]              wrPtr_ff;
   logic [PW-1:0]              rdPtr_ff;
   logic [PW:0]                pendCnt_ff;
   swb_pkg::swb_burst_t        state_ff;
   logic [1:0]                 clk_ff;
   swb_pkg::swb_cmd_t          cur_ff;
   logic                       dataEnd_ff;
   logic                       autoClose_ff;
   logic [swb_pkg::BANKS-1:0]  bankOpen_ff;
   logic [LANES*8-1:0]         memArr [0:(1<<swb_pkg::MEM_AW)-1];

   logic [5:0]                 wl;
   logic                       push;
   logic                       headDue;
   swb_pkg::swb_cmd_t          pushInfo;
   swb_pkg::swb_cmd_t          curInfo;
   logic [1:0]                 curClk;
   logic                       curValid;
   logic                       curLast;
   logic                       curKeep;
   logic [SLOTS-1:0]           slotWe;
   logic [LANES*8-1:0]         slotDat [0:1];
   logic [swb_pkg::MEM_AW-1:0] wAddr   [0:1];

   assign curCfg = '{burstLen: modeReg_ff[swb_pkg::MODE_BL_LSB +: 2],
                     maskEn:   modeReg_ff[swb_pkg::MODE_MASK_BIT],
                     invEn:    modeReg_ff[swb_pkg::MODE_INV_BIT],
                     crcEn:    modeReg_ff[swb_pkg::MODE_CRC_BIT],
                     pre2:     modeReg_ff[swb_pkg::MODE_PRE2_BIT],
                     al:       alReg_ff,
                     column_write_latency:      cwlReg_ff};

   assign cwlLow = curCfg.pre2 && (cwlReg_ff <= swb_pkg::CWL_LOWEST);
   assign spEvt  = spSync_ff != spSeen_ff;
   assign errSet = {spEvt, cwlLow};

   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         modeReg_ff  <= swb_pkg::MODE_RST;
         alReg_ff    <= swb_pkg::AL_RST;
         cwlReg_ff   <= swb_pkg::CWL_RST;
         peekAddr_ff <= '0;
      end
      else if (regWr)
      begin
         case (regAddr)
            swb_pkg::REG_MODE:      modeReg_ff  <= regWdata[swb_pkg::MODE_W-1:0];
            swb_pkg::REG_LAT:
            begin
               alReg_ff  <= regWdata[swb_pkg::LAT_AL_LSB +: swb_pkg::AL_W];
               cwlReg_ff <= regWdata[swb_pkg::LAT_CWL_LSB +: swb_pkg::CWL_W];
            end
            swb_pkg::REG_PEEK_ADDR: peekAddr_ff <= regWdata[swb_pkg::MEM_AW-1:0];
            default:                peekAddr_ff <= peekAddr_ff;
         endcase
      end
   end

   // sticky errors, write one to clear; a new event beats the clear
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
         err_ff <= 2'h0;
      else if (regWr && regAddr == swb_pkg::REG_ERR)
         err_ff <= (err_ff & ~regWdata[1:0]) | errSet;
      else
         err_ff <= err_ff | errSet;
   end

   // read data stands one cycle for each cycle of regRd, zero otherwise
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
         rdata_ff <= 32'h0000_0000;
      else if (!regRd)
         rdata_ff <= 32'h0000_0000;
      else
      begin
         case (regAddr)
            swb_pkg::REG_MODE:      rdata_ff <= 32'(modeReg_ff);
            swb_pkg::REG_LAT:       rdata_ff <= 32'({cwlReg_ff, 3'h0, alReg_ff});
            swb_pkg::REG_STATUS:    rdata_ff <= 32'({curCfg.maskEn && curCfg.invEn,
                                                     // busy also while a change waits its turn
                                                     (reqTgl_ff != ackSync_ff) ||
                                                        (curCfg != cfgHold_ff),
                                                     curCfg.crcEn && curCfg.maskEn,
                                                     bankSync_ff});
            swb_pkg::REG_ERR:       rdata_ff <= 32'(err_ff);
            swb_pkg::REG_PEEK_ADDR: rdata_ff <= 32'(peekAddr_ff);
            // peek may tear if the link writes the same word at that moment
            swb_pkg::REG_PEEK_DATA: rdata_ff <= 32'(memArr[peekAddr_ff]);
            default:                rdata_ff <= 32'h0000_0000;
         endcase
      end
   end

   // configuration handshake toward the link; hold is stable while a request is open
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         cfgHold_ff <= '{burstLen: swb_pkg::BL_EIGHT, al: swb_pkg::AL_RST,
                         column_write_latency: swb_pkg::CWL_RST, default: 1'b0};
         reqTgl_ff  <= 1'b0;
      end
      else if (reqTgl_ff == ackSync_ff && curCfg != cfgHold_ff)
      begin
         cfgHold_ff <= curCfg;
         reqTgl_ff  <= ~reqTgl_ff;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         ackMeta_ff  <= 1'b0;
         ackSync_ff  <= 1'b0;
         bankMeta_ff <= '0;
         bankSync_ff <= '0;
         spMeta_ff   <= 1'b0;
         spSync_ff   <= 1'b0;
         spSeen_ff   <= 1'b0;
      end
      else
      begin
         ackMeta_ff  <= reqSeen_ff;
         ackSync_ff  <= ackMeta_ff;
         bankMeta_ff <= bankOpen_ff;
         bankSync_ff <= bankMeta_ff;
         spMeta_ff   <= spTgl_ff;
         spSync_ff   <= spMeta_ff;
         spSeen_ff   <= spSync_ff;
      end
   end

   // link side
   always_ff @(posedge lclk)
   begin
      lrstMeta_ff <= rst_n;
      lrst_n      <= lrstMeta_ff;
   end

   always_ff @(posedge lclk)
   begin
      if (!lrst_n)
      begin
         reqMeta_ff <= 1'b0;
         reqSync_ff <= 1'b0;
         reqSeen_ff <= 1'b0;
         lcfg_ff    <= '{burstLen: swb_pkg::BL_EIGHT, al: swb_pkg::AL_RST,
                         column_write_latency: swb_pkg::CWL_RST, default: 1'b0};
      end
      else
      begin
         reqMeta_ff <= reqTgl_ff;
         reqSync_ff <= reqMeta_ff;
         if (reqSync_ff != reqSeen_ff)
         begin
            lcfg_ff    <= cfgHold_ff;
            reqSeen_ff <= reqSync_ff;
         end
      end
   end

   assign wl   = 6'(lcfg_ff.al) + 6'(lcfg_ff.column_write_latency);
   assign push = wrCmd && (pendCnt_ff != (PW+1)'(PEND_DEPTH));

   always_comb
   begin
      pushInfo.bank      = cmdBank;
      pushInfo.colHi     = cmdColHi;
      pushInfo.autoClose = addrBitTen;
      pushInfo.fixedChop = lcfg_ff.burstLen == swb_pkg::BL_CHOP;
      pushInfo.chop      = (lcfg_ff.burstLen == swb_pkg::BL_CHOP) ||
                           (lcfg_ff.burstLen == swb_pkg::BL_SELECT && !addrBitTwelve);
   end

   // spacing watch for two-clock preamble mode
   always_ff @(posedge lclk)
   begin
      if (!lrst_n)
      begin
         age_ff      <= 3'h7;
         sinceCmd_ff <= 7'h7F;
         spTgl_ff    <= 1'b0;
      end
      else
      begin
         age_ff      <= wrCmd ? 3'h1 : (age_ff == 3'h7 ? age_ff : age_ff + 3'h1);
         sinceCmd_ff <= wrCmd ? 7'h01 : (sinceCmd_ff == 7'h7F ? sinceCmd_ff : sinceCmd_ff + 7'h01);
         if (wrCmd && lcfg_ff.pre2 && age_ff == swb_pkg::SPACING_BANNED)
            spTgl_ff <= ~spTgl_ff;
      end
   end

   // pending writes, each due at a timer stamp
   assign headDue = (pendCnt_ff != '0) && (pendDue[rdPtr_ff] == timer_ff);

   always_ff @(posedge lclk)
   begin
      if (!lrst_n)
      begin
         timer_ff   <= 7'h00;
         wrPtr_ff   <= '0;
         rdPtr_ff   <= '0;
         pendCnt_ff <= '0;
      end
      else
      begin
         timer_ff <= timer_ff + 7'h01;
         if (push)
         begin
            pendInfo[wrPtr_ff] <= pushInfo;
            pendDue[wrPtr_ff]  <= timer_ff + 7'(wl);
            wrPtr_ff           <= wrPtr_ff + PW'(1);
         end
         if (headDue)
            rdPtr_ff <= rdPtr_ff + PW'(1);
         pendCnt_ff <= pendCnt_ff + (PW+1)'(push) - (PW+1)'(headDue);
      end
   end

   // burst engine, two beats per link clock
   assign curValid = headDue || (state_ff == swb_pkg::BST_RUN);
   assign curInfo  = headDue ? pendInfo[rdPtr_ff] : cur_ff;
   assign curClk   = headDue ? 2'h0 : clk_ff;
   assign curLast  = curValid && (curClk == (curInfo.fixedChop ? swb_pkg::CHOP_LAST_CLK
                                                               : swb_pkg::FULL_LAST_CLK));
   assign curKeep  = curValid && (!curInfo.chop || curClk < swb_pkg::CHOP_KEEP_CLKS);

   always_ff @(posedge lclk)
   begin
      if (!lrst_n)
      begin
         state_ff <= swb_pkg::BST_IDLE;
         clk_ff   <= 2'h0;
         cur_ff   <= '0;
      end
      else
      begin
         case (state_ff)
            swb_pkg::BST_IDLE,
            swb_pkg::BST_RUN:
            begin
               state_ff <= (curValid && !curLast) ? swb_pkg::BST_RUN : swb_pkg::BST_IDLE;
               clk_ff   <= curClk + 2'h1;
               cur_ff   <= curInfo;
            end
            default:
               state_ff <= swb_pkg::BST_IDLE;
         endcase
      end
   end

   // end marks the first edge after the last beat
   always_ff @(posedge lclk)
   begin
      if (!lrst_n)
      begin
         dataEnd_ff   <= 1'b0;
         autoClose_ff <= 1'b0;
         bankOpen_ff  <= '0;
      end
      else
      begin
         dataEnd_ff   <= curLast;
         autoClose_ff <= curLast && curInfo.autoClose;
         for (int b = 0; b < swb_pkg::BANKS; b++)
         begin
            if (curLast && curInfo.autoClose && curInfo.bank == (swb_pkg::BANK_W)'(b))
               bankOpen_ff[b] <= 1'b0;
            else if (actCmd && cmdBank == (swb_pkg::BANK_W)'(b))
               bankOpen_ff[b] <= 1'b1;
         end
      end
   end

   // shared mask / inversion pin per lane, x8 or x16 only
   genvar g;
   generate
      for (g = 0; g < SLOTS; g++)
      begin : g_slot
         assign slotWe[g] = curKeep &&
                            laneKeep(lcfg_ff.maskEn, lcfg_ff.invEn, byteLaneMaskN[g]);
         assign slotDat[g/LANES][(g%LANES)*8 +: 8] =
            laneVal(lcfg_ff.invEn, byteLaneMaskN[g], dq[g*8 +: 8]);
      end
      for (g = 0; g < 2; g++)
      begin : g_addr
         assign wAddr[g] = {curInfo.bank, curInfo.colHi, curClk, 1'(g)};
      end
   endgenerate

   always_ff @(posedge lclk)
   begin
      for (int h = 0; h < 2; h++)
         for (int l = 0; l < LANES; l++)
            if (slotWe[h*LANES+l])
               memArr[wAddr[h]][l*8 +: 8] <= slotDat[h][l*8 +: 8];
   end

   assign regRdata     = rdata_ff;
   assign dataEnd      = dataEnd_ff;
   assign autoCloseEvt = autoClose_ff;
   assign bankOpen     = bankOpen_ff;

   a_latency_start: assert property (@(posedge lclk) disable iff (!lrst_n)
      (headDue && pendCnt_ff == 1 && sinceCmd_ff != 7'h7F) |-> sinceCmd_ff == 7'(wl))
      else $error("first beat not at write latency");

   a_eight_length: assert property (@(posedge lclk) disable iff (!lrst_n)
      (headDue && !pendInfo[rdPtr_ff].fixedChop && !$past(headDue))
         |-> !dataEnd_ff [*4] ##1 dataEnd_ff)
      else $error("eight-beat burst length wrong");

   a_chop_fixed: assert property (@(posedge lclk) disable iff (!lrst_n)
      (headDue && pendInfo[rdPtr_ff].fixedChop) |-> ##2 dataEnd_ff)
      else $error("fixed chop burst length wrong");

   a_chop_upper: assert property (@(posedge lclk) disable iff (!lrst_n)
      (curValid && curInfo.chop && curClk >= 2'h2) |-> slotWe == '0
         ##1 (memArr[$past(wAddr[0])] == $past(memArr[wAddr[0]]) &&
              memArr[$past(wAddr[1])] == $past(memArr[wAddr[1]])))
      else $error("chopped burst wrote upper beats");

   a_otf_select: assert property (@(posedge lclk) disable iff (!lrst_n)
      (push && lcfg_ff.burstLen == swb_pkg::BL_SELECT)
         |=> pendInfo[$past(wrPtr_ff)].chop == !$past(addrBitTwelve))
      else $error("per-command length select wrong");

   a_autoclose_bank: assert property (@(posedge lclk) disable iff (!lrst_n)
      (curLast && curInfo.autoClose) |=> autoClose_ff && !bankOpen_ff[$past(curInfo.bank)])
      else $error("bank not closed after burst");

   a_plain_open: assert property (@(posedge lclk) disable iff (!lrst_n)
      (curLast && !curInfo.autoClose && bankOpen_ff[curInfo.bank])
         |=> bankOpen_ff[$past(curInfo.bank)])
      else $error("plain write closed the bank");

   a_mask_hold: assert property (@(posedge lclk) disable iff (!lrst_n)
      (curValid && !slotWe[0] && !slotWe[LANES])
         |=> memArr[$past(wAddr[0])][7:0] == $past(memArr[wAddr[0]][7:0]))
      else $error("masked lane altered array");

   a_mask_store: assert property (@(posedge lclk) disable iff (!lrst_n)
      slotWe[0] |=> memArr[$past(wAddr[0])][7:0] == $past(slotDat[0][7:0]))
      else $error("unmasked lane not stored");

   a_crc_status: assert property (@(posedge mclk) disable iff (!rst_n)
      (regRd && regAddr == swb_pkg::REG_STATUS) |=> regRdata[swb_pkg::STAT_CRC_BIT] ==
         ($past(modeReg_ff[swb_pkg::MODE_CRC_BIT]) && $past(modeReg_ff[swb_pkg::MODE_MASK_BIT])))
      else $error("crc persistence status wrong");

endmodule // swb_write_burst
`default_nettype wire

// file: testbench/swb_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
module swb_ctrl_model (
   // link
   input  wire logic   lclk,
   input  wire logic   dataEnd,
   output logic        actCmd,
   output logic        wrCmd,
   output logic [1:0]  cmdBank,
   output logic [1:0]  cmdColHi,
   output logic        addrBitTen,
   output logic        addrBitTwelve,
   output logic [31:0] dq,
   output logic [3:0]  byteLaneMaskN
);
   initial
   begin
      actCmd = 1'b0;
      wrCmd = 1'b0;
      cmdBank = 2'h0;
      cmdColHi = 2'h0;
      addrBitTen = 1'b0;
      addrBitTwelve = 1'b0;
      dq = 32'h0;
      byteLaneMaskN = 4'hF;
   end
   task automatic act(input logic [1:0] b);
      @(posedge lclk);
      actCmd <= 1'b1;
      cmdBank <= b;
      @(posedge lclk);
      actCmd <= 1'b0;
      cmdBank <= ~b;
   endtask
   // e: edges from the command edge to the one that raised dataEnd
   task automatic write(input logic [1:0] b, input logic [1:0] c, input logic a10,
                        input logic a12, input int wl, input logic [127:0] d,
                        input logic [3:0] mk, output int e);
      int k;
      e = -1;
      @(posedge lclk);
      wrCmd <= 1'b1;
      cmdBank <= b;
      cmdColHi <= c;
      addrBitTen <= a10;
      addrBitTwelve <= a12;
      for (k = 1; k <= wl + 12; k++)
      begin
         @(posedge lclk);
         wrCmd <= 1'b0;
         cmdColHi <= ~c;
         addrBitTen <= ~a10;
         addrBitTwelve <= ~a12;
         if (dataEnd === 1'b1 && e < 0)
            e = k - 1;
         if (k >= wl && k < wl + 4)
         begin
            dq <= d[(k - wl) * 32 +: 32];
            byteLaneMaskN <= mk;
         end
         else
         begin
            // released bus toggles so stale data never passes for valid
            dq <= ~dq;
            byteLaneMaskN <= ~byteLaneMaskN;
         end
      end
   endtask
endmodule // swb_ctrl_model
`default_nettype wire

// file: testbench/test_sdram_write_burst.sv
`timescale 1ns/1ps
`default_nettype none
module test_sdram_write_burst;
   typedef struct {
      logic [5:0] mode;
      logic [4:0] al;
      logic [4:0] column_write_latency;
      logic [1:0] bank;
      logic [1:0] col;
      logic       a10;
      logic       a12;
      logic [3:0] mk;
      int         endOff;
      int         nclk;
   } swb_row_t;
   logic mclk = 1'b0;
   logic lclk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] regAddr = 8'h00;
   logic [31:0] regWdata = 32'h0;
   logic regWr = 1'b0;
   logic regRd = 1'b0;
   logic [31:0] regRdata;
   logic actCmd, wrCmd, addrBitTen, addrBitTwelve, dataEnd, autoCloseEvt, lastAce;
   logic [1:0] cmdBank, cmdColHi;
   logic [31:0] dq;
   logic [3:0] byteLaneMaskN, bankOpen;
   logic [15:0] shadow [128];
   swb_row_t rows [6];
   int fails = 0;
   int testsRun = 0;
   always #2 mclk = ~mclk;
   always #7.5 lclk = ~lclk;
   always @(posedge lclk)
      if (dataEnd === 1'b1)
         lastAce <= autoCloseEvt;
   // two lanes: the x16 case where the mask pin exists
   swb_write_burst #(.LANES(2), .PEND_DEPTH(16)) swb_write_burst_i (
      .mclk(mclk), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
      .regRd(regRd), .regRdata(regRdata), .lclk(lclk), .actCmd(actCmd), .wrCmd(wrCmd),
      .cmdBank(cmdBank), .cmdColHi(cmdColHi), .addrBitTen(addrBitTen),
      .addrBitTwelve(addrBitTwelve), .dq(dq), .byteLaneMaskN(byteLaneMaskN),
      .dataEnd(dataEnd), .autoCloseEvt(autoCloseEvt), .bankOpen(bankOpen));
   swb_ctrl_model swb_ctrl_model_i (
      .lclk(lclk), .dataEnd(dataEnd), .actCmd(actCmd), .wrCmd(wrCmd), .cmdBank(cmdBank),
      .cmdColHi(cmdColHi), .addrBitTen(addrBitTen), .addrBitTwelve(addrBitTwelve),
      .dq(dq), .byteLaneMaskN(byteLaneMaskN));
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      testsRun++;
      if (got !== exp)
      begin
         fails++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic regW(input logic [7:0] a, input logic [31:0] v);
      @(posedge mclk);
      regWr <= 1'b1;
      regAddr <= a;
      regWdata <= v;
      @(posedge mclk);
      regWr <= 1'b0;
   endtask
   task automatic regR(input logic [7:0] a, output logic [31:0] v);
      @(posedge mclk);
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge mclk);
      regRd <= 1'b0;
      @(posedge mclk);
      v = regRdata;
   endtask
   task automatic setCfg(input logic [5:0] m, input logic [4:0] al, input logic [4:0] column_write_latency,
                         output logic [31:0] s);
      int n;
      regW(swb_pkg::REG_MODE, {26'h0, m});
      regW(swb_pkg::REG_LAT, {19'h0, column_write_latency, 3'h0, al});
      repeat (4) @(posedge mclk);
      s = 32'hFFFF_FFFF;
      for (n = 0; n < 100 && s[swb_pkg::STAT_BUSY_BIT] !== 1'b0; n++)
         regR(swb_pkg::REG_STATUS, s);
   endtask
   task automatic doReset();
      rst_n <= 1'b0;
      // held past four link clocks so the link side sees it too
      repeat (16) @(posedge mclk);
      rst_n <= 1'b1;
      repeat (20) @(posedge mclk);
   endtask
   task automatic finalReport();
      $display("comparisons %0d mismatches %0d", testsRun, fails);
      if (fails == 0 && testsRun > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial
   begin
      repeat (40000) @(posedge mclk);
      fails++;
      finalReport();
   end
   initial
   begin
      logic [31:0] s;
      logic [127:0] d;
      logic [7:0] byt;
      logic [6:0] idx;
      swb_row_t w;
      int r, k, i, e;
      // mask and inversion never both on
      rows[0] = '{6'h00, 5'h00, 5'h09, 2'h0, 2'h0, 1'b0, 1'b0, 4'hF, 13, 4};
      rows[1] = '{6'h01, 5'h00, 5'h09, 2'h0, 2'h0, 1'b0, 1'b0, 4'hF, 13, 2};
      rows[2] = '{6'h05, 5'h00, 5'h09, 2'h0, 2'h0, 1'b0, 1'b1, 4'hA, 13, 4};
      rows[3] = '{6'h02, 5'h00, 5'h09, 2'h0, 2'h0, 1'b1, 1'b1, 4'hF, 11, 2};
      rows[4] = '{6'h18, 5'h0A, 5'h09, 2'h1, 2'h1, 1'b0, 1'b0, 4'h5, 23, 4};
      rows[5] = '{6'h14, 5'h00, 5'h09, 2'h1, 2'h1, 1'b1, 1'b0, 4'h6, 13, 4};
      doReset();
      regR(swb_pkg::REG_MODE, s);
      check(s, 32'h0);
      regR(swb_pkg::REG_LAT, s);
      check(s, 32'h0000_0900);
      regR(8'h1C, s);
      check(s, 32'h0);
      check({28'h0, bankOpen}, 32'h0);
      for (r = 0; r < 6; r++)
      begin
         w = rows[r];
         d = 128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210 ^ {16{8'(r * 37)}};
         setCfg(w.mode, w.al, w.column_write_latency, s);
         check(32'(s[swb_pkg::STAT_CRC_BIT]), 32'(w.mode[4] & w.mode[2]));
         swb_ctrl_model_i.act(w.bank);
         swb_ctrl_model_i.write(w.bank, w.col, w.a10, w.a12, int'(w.al) + int'(w.column_write_latency),
                                d, w.mk, e);
         check(32'(e), 32'(w.endOff));
         check(32'(lastAce), 32'(w.a10));
         check(32'(bankOpen[w.bank]), 32'(!w.a10));
         for (k = 0; k < w.nclk; k++)
            for (i = 0; i < 4; i++)
            begin
               byt = d[k * 32 + i * 8 +: 8];
               idx = {w.bank, w.col, 2'(k), 1'(i / 2)};
               if (w.mode[3])
                  shadow[idx][(i % 2) * 8 +: 8] = w.mk[i] ? byt : ~byt;
               else if (!w.mode[2] || w.mk[i])
                  shadow[idx][(i % 2) * 8 +: 8] = byt;
            end
         for (i = 0; i < 8; i++)
         begin
            regW(swb_pkg::REG_PEEK_ADDR, {25'h0, w.bank, w.col, 3'(i)});
            regR(swb_pkg::REG_PEEK_DATA, s);
            check(s, {16'h0, shadow[{w.bank, w.col, 3'(i)}]});
         end
      end
      setCfg(6'h20, 5'h00, 5'h09, s);
      regR(swb_pkg::REG_ERR, s);
      check(32'(s[swb_pkg::ERR_CWL_BIT]), 32'h1);
      check(32'(s[swb_pkg::ERR_SPC_BIT]), 32'h0);
      setCfg(6'h20, 5'h00, 5'h0A, s);
      regW(swb_pkg::REG_ERR, 32'h1);
      regR(swb_pkg::REG_ERR, s);
      check(32'(s[swb_pkg::ERR_CWL_BIT]), 32'h0);
      doReset();
      regR(swb_pkg::REG_MODE, s);
      check(s, 32'h0);
      check({28'h0, bankOpen}, 32'h0);
      finalReport();
   end
endmodule // test_sdram_write_burst
`default_nettype wire
